// ---- gpb_pkg.sv ----
// Purpose: shared constants and types for the gpio port bank
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes:   each port owns a 32-byte window of six registers
package gpb_pkg;
   localparam int unsigned GPB_PORTS     = 6;
   localparam int unsigned GPB_PINS      = 8;
   localparam int unsigned GPB_ADDR_W    = 8;
   localparam int unsigned GPB_NO_ALT    = 2;

   // byte address = port * stride + register offset
   localparam logic [7:0] GPB_PORT_STRIDE = 8'h20;
   localparam logic [4:0] GPB_OFS_FSEL    = 5'h00;
   localparam logic [4:0] GPB_OFS_DIR     = 5'h04;
   localparam logic [4:0] GPB_OFS_DIN     = 5'h08;
   localparam logic [4:0] GPB_OFS_DOUT    = 5'h0c;
   localparam logic [4:0] GPB_OFS_PULL    = 5'h10;
   localparam logic [4:0] GPB_OFS_HYST    = 5'h14;

   localparam logic [7:0] GPB_RST_FSEL    = 8'h00;
   localparam logic [7:0] GPB_RST_DIR     = 8'h00;
   localparam logic [7:0] GPB_RST_PULL    = 8'h00;
   localparam logic [7:0] GPB_RST_HYST    = 8'h00;

   localparam logic [1:0] GPB_RESP_OKAY   = 2'h0;
   localparam logic [1:0] GPB_RESP_SLVERR = 2'h2;

   // per-port pad controls, one bit per pin
   typedef struct packed {
      logic [7:0] oe_n;
      logic [7:0] out;
      logic [7:0] pull;
      logic [7:0] schm;
      logic [7:0] ibuf;
   } gpb_pad_ctl_t;

   // alternate-function peripheral side, one bit per pin
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } gpb_periph_drv_t;
endpackage

// ---- gpb_port_bank.sv ----
// Purpose: six 8-pin gpio ports, alternate-function muxing on all but the first two
// Assumes: pins are asynchronous, peripherals share clk
// Notes:   output latch has no reset; pad controls are registered
`timescale 1ns/1ns
module gpb_port_bank
   import gpb_pkg::*;
#(
   parameter int unsigned NP = gpb_pkg::GPB_PORTS
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // axi4-lite write
   input  wire logic [GPB_ADDR_W-1:0]       s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // axi4-lite read
   input  wire logic [GPB_ADDR_W-1:0]       s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // pads
   input  wire logic [NP-1:0][7:0]          pin_in,
   output gpb_pkg::gpb_pad_ctl_t [NP-1:0]   pad_ctl,
   // alternate-function peripherals
   input  gpb_pkg::gpb_periph_drv_t [NP-1:0] periph_drv,
   output logic [NP-1:0][7:0]               periph_in
);
   import gpb_pkg::*;

   logic [NP-1:0][7:0] fsel_q;
   logic [NP-1:0][7:0] dir_q;
   logic [NP-1:0][7:0] dout_q;
   logic [NP-1:0][7:0] pull_q;
   logic [NP-1:0][7:0] hyst_q;
   logic [NP-1:0][7:0] pin_s1_q;
   logic [NP-1:0][7:0] pin_s2_q;
   logic [NP-1:0]      rd_din_q;
   logic [NP-1:0][7:0] alt_v;

   logic [GPB_ADDR_W-1:0] aw_addr_q;
   logic                  aw_held_q;
   logic [7:0]            w_data_q;
   logic                  w_lane_q;
   logic                  w_held_q;
   logic                  wr_fire;
   logic [2:0]            wr_port;
   logic [4:0]            wr_ofs;
   logic                  wr_ok;
   logic                  ar_fire;
   logic [2:0]            rd_port;
   logic [4:0]            rd_ofs;
   logic                  rd_ok;
   logic [7:0]            rd_val;

   // pin synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   // effective select: fixed gpio on the first ports
   always_comb begin
      alt_v = fsel_q;
      for (int p = 0; p < GPB_NO_ALT; p++) begin
         alt_v[p] = 8'h00;
      end
   end

   // address decode
   assign wr_port = aw_addr_q[7:5];
   assign wr_ofs  = aw_addr_q[4:0];
   assign wr_ok   = (32'(wr_port) < NP) && (wr_ofs <= GPB_OFS_HYST) && (wr_ofs[1:0] == 2'h0);
   assign rd_port = s_axi_araddr[7:5];
   assign rd_ofs  = s_axi_araddr[4:0];
   assign rd_ok   = (32'(rd_port) < NP) && (rd_ofs <= GPB_OFS_HYST) && (rd_ofs[1:0] == 2'h0);
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign ar_fire = s_axi_arvalid && s_axi_arready;

   // write address and data captured in either order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held_q     <= 1'b0;
         aw_addr_q     <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q     <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_held_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held_q     <= 1'b0;
         w_data_q     <= '0;
         w_lane_q     <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q     <= 1'b1;
         w_data_q     <= s_axi_wdata[7:0];
         w_lane_q     <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_held_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= GPB_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? GPB_RESP_OKAY : GPB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control registers, writes ignored on the input register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fsel_q <= {NP{GPB_RST_FSEL}};
         dir_q  <= {NP{GPB_RST_DIR}};
         pull_q <= {NP{GPB_RST_PULL}};
         hyst_q <= {NP{GPB_RST_HYST}};
      end else if (wr_fire && wr_ok && w_lane_q) begin
         case (wr_ofs)
            GPB_OFS_FSEL: begin
               if (32'(wr_port) >= GPB_NO_ALT) begin
                  fsel_q[wr_port] <= w_data_q;
               end
            end
            GPB_OFS_DIR:  dir_q[wr_port]  <= w_data_q;
            GPB_OFS_PULL: pull_q[wr_port] <= w_data_q;
            GPB_OFS_HYST: hyst_q[wr_port] <= w_data_q;
            default: ;
         endcase
      end
   end

   // output latch keeps its value through reset
   always_ff @(posedge clk) begin
      if (wr_fire && wr_ok && w_lane_q && wr_ofs == GPB_OFS_DOUT) begin
         dout_q[wr_port] <= w_data_q;
      end
   end

   // read mux
   always_comb begin
      rd_val = 8'h00;
      if (rd_ok) begin
         case (rd_ofs)
            GPB_OFS_FSEL: rd_val = alt_v[rd_port];
            GPB_OFS_DIR:  rd_val = dir_q[rd_port];
            GPB_OFS_DIN:  rd_val = pin_s2_q[rd_port];
            GPB_OFS_DOUT: rd_val = dout_q[rd_port];
            GPB_OFS_PULL: rd_val = pull_q[rd_port];
            GPB_OFS_HYST: rd_val = hyst_q[rd_port];
            default:      rd_val = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= GPB_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_val};
         s_axi_rresp   <= rd_ok ? GPB_RESP_OKAY : GPB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // flags a port whose input register is being read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_din_q <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            rd_din_q[p] <= ar_fire && rd_ok && rd_ofs == GPB_OFS_DIN && 32'(rd_port) == p;
         end
      end
   end

   // registered pad controls, every pin updated each cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_ctl   <= '{default: '{oe_n: 8'hff, default: 8'h00}};
         periph_in <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            for (int n = 0; n < GPB_PINS; n++) begin
               if (alt_v[p][n]) begin
                  pad_ctl[p].oe_n[n] <= ~periph_drv[p].oe[n];
                  pad_ctl[p].out[n]  <= periph_drv[p].out[n];
               end else begin
                  pad_ctl[p].oe_n[n] <= ~dir_q[p][n];
                  pad_ctl[p].out[n]  <= dout_q[p][n];
               end
               pad_ctl[p].pull[n] <= pull_q[p][n] & ~alt_v[p][n] & ~dir_q[p][n];
               pad_ctl[p].schm[n] <= hyst_q[p][n] | alt_v[p][n];
               pad_ctl[p].ibuf[n] <= alt_v[p][n] | hyst_q[p][n] | rd_din_q[p];
               periph_in[p][n]    <= pin_s2_q[p][n] & (alt_v[p][n] | hyst_q[p][n]);
            end
         end
      end
   end

   // checks
   chk_gpio_no_alt: assert property (@(posedge clk) disable iff (rst)
      fsel_q[0] == 8'h00 && fsel_q[1] == 8'h00)
      else $error("first ports gained a function select");

   chk_dir_to_pad: assert property (@(posedge clk) disable iff (rst)
      wr_fire && wr_ok && w_lane_q && wr_ofs == GPB_OFS_DIR && 32'(wr_port) < GPB_NO_ALT
      |=> ##1 pad_ctl[$past(wr_port, 2)].oe_n == ~$past(w_data_q, 2))
      else $error("direction write did not reach pad enable");

   chk_write_resp: assert property (@(posedge clk) disable iff (rst)
      wr_fire |=> s_axi_bvalid && (s_axi_bresp == GPB_RESP_OKAY) == $past(wr_ok))
      else $error("write response missing or wrong");

   chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");

   chk_dout_readback: assert property (@(posedge clk) disable iff (rst)
      ar_fire && rd_ok && rd_ofs == GPB_OFS_DOUT
      |=> s_axi_rdata[7:0] == $past(dout_q[rd_port]))
      else $error("latch read not last written value");

   chk_din_live: assert property (@(posedge clk) disable iff (rst)
      ar_fire && rd_ok && rd_ofs == GPB_OFS_DIN
      |=> s_axi_rdata[7:0] == $past(pin_s2_q[rd_port]) && s_axi_rdata[31:8] == 24'h000000)
      else $error("input read not the pin level");

   chk_ibuf_on_read: assert property (@(posedge clk) disable iff (rst)
      ar_fire && rd_ok && rd_ofs == GPB_OFS_DIN |=> ##1 pad_ctl[$past(rd_port, 2)].ibuf == 8'hff)
      else $error("input buffer not opened for read");

   chk_pull_alt_off: assert property (@(posedge clk) disable iff (rst)
      ##1 (pad_ctl[3].pull & ($past(alt_v[3]) | $past(dir_q[3]))) == 8'h00)
      else $error("pull-up on while driving or alternate");

   chk_schmitt_alt: assert property (@(posedge clk) disable iff (rst)
      alt_v[3] != 8'h00
      |=> (pad_ctl[3].schm & pad_ctl[3].ibuf & $past(alt_v[3])) == $past(alt_v[3]))
      else $error("alternate pin lost hysteresis or input");

   chk_alt_drive: assert property (@(posedge clk) disable iff (rst)
      alt_v[3][0] |=> pad_ctl[3].oe_n[0] == ~$past(periph_drv[3].oe[0])
                  && pad_ctl[3].out[0] == $past(periph_drv[3].out[0]))
      else $error("alternate pin not driven by peripheral");
endmodule

// ---- gpb_pad_model.sv ----
// Purpose: pad and board model for the gpio port bank
// Assumes: board drive per pin from the bench, weak pull-up to one
// Notes:   an undriven pin without pull-up toggles every cycle
`timescale 1ns/1ns
module gpb_pad_model
   import gpb_pkg::*;
(
   // clock
   input  wire logic                      clk,
   // pad controls from the bank
   input  gpb_pkg::gpb_pad_ctl_t [5:0]    pad_ctl,
   // board side
   input  wire logic [5:0][7:0]           ext_val,
   input  wire logic [5:0][7:0]           ext_en,
   output logic [5:0][7:0]                pin_in
);
   logic tog_q = 1'b0;
   always @(posedge clk) begin
      tog_q <= ~tog_q;
   end
   // own drive wins, then board, then pull-up, else floating
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         for (int b = 0; b < 8; b++) begin
            pin_in[p][b] = !pad_ctl[p].oe_n[b] ? pad_ctl[p].out[b] :
                           ext_en[p][b] ? ext_val[p][b] :
                           pad_ctl[p].pull[b] ? 1'b1 : tog_q;
         end
      end
   end
endmodule

// ---- tb.sv ----
// Purpose: register and pad tests for the gpio port bank
// Assumes: axi4-lite master tasks, pads modelled by gpb_pad_model
// Notes:   one write and one read at a time, bounded waits
`timescale 1ns/1ns
module tb;
   import gpb_pkg::*;
   logic clk = 1'b0, rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [5:0][7:0] pin_in, periph_in, ext_val = '0, ext_en = '0;
   gpb_pad_ctl_t [5:0] pad_ctl;
   gpb_periph_drv_t [5:0] periph_drv = '0;
   int err_count = 0, check_count = 0;
   logic [7:0] pat, e;
   always #20 clk = ~clk;
   gpb_port_bank #(.NP(6)) i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_in(pin_in), .pad_ctl(pad_ctl),
      .periph_drv(periph_drv), .periph_in(periph_in));
   gpb_pad_model i_pads (.clk(clk), .pad_ctl(pad_ctl), .ext_val(ext_val),
      .ext_en(ext_en), .pin_in(pin_in));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   function automatic logic [7:0] ad(input int p, input logic [4:0] o);
      return 8'(p) * GPB_PORT_STRIDE + {3'h0, o};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
      int n;
      n = 0;
      awaddr <= a; wdata <= {24'h0, d}; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge clk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
         if (n > 40) begin err_count++; wrap_up(); end
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge clk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
         if (n > 40) begin err_count++; wrap_up(); end
      end
      rv = rdata; r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wt();
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int p = 0; p < 6; p++) begin
         rd(ad(p, GPB_OFS_FSEL)); chk("fsel rst", rv, 32'h0);
         chk("rd resp", r, GPB_RESP_OKAY);
         rd(ad(p, GPB_OFS_DIR)); chk("dir rst", rv, 32'h0);
         rd(ad(p, GPB_OFS_HYST)); chk("hyst rst", rv, 32'h0);
         chk("oe_n rst", pad_ctl[p].oe_n, 8'hff);
      end
      $display("test reset done");
      for (int p = 0; p < 6; p++) begin
         pat = 8'h5a ^ 8'(p);
         ext_val[p] <= ~pat; ext_en[p] <= 8'hff;
         wr(ad(p, GPB_OFS_DOUT), pat); wr(ad(p, GPB_OFS_DIR), 8'hc3); wt();
         chk("pad out", pad_ctl[p].out, pat);
         chk("pad oe_n", pad_ctl[p].oe_n, 8'h3c);
         e = (pat & 8'hc3) | (~pat & 8'h3c);
         rd(ad(p, GPB_OFS_DIN)); chk("din", rv, {24'h0, e});
         wr(ad(p, GPB_OFS_DIN), 8'h00); rd(ad(p, GPB_OFS_DIN));
         chk("din ro", rv, {24'h0, e});
         rd(ad(p, GPB_OFS_DOUT)); chk("dout rb", rv, {24'h0, pat});
      end
      $display("test gpio done");
      wr(ad(0, GPB_OFS_FSEL), 8'hff); chk("fsel0 resp", r, GPB_RESP_OKAY);
      rd(ad(0, GPB_OFS_FSEL)); chk("fsel0", rv, 32'h0);
      wt(); chk("fsel0 oe_n", pad_ctl[0].oe_n, 8'h3c);
      wr(ad(1, 5'h18), 8'hff); chk("unmapped wr", r, GPB_RESP_SLVERR);
      rd(ad(6, GPB_OFS_DIR)); chk("unmapped rd", r, GPB_RESP_SLVERR);
      $display("test map done");
      wr(ad(3, GPB_OFS_DIR), 8'h00); wr(ad(3, GPB_OFS_PULL), 8'hff);
      ext_en[3] <= 8'h00;
      wr(ad(3, GPB_OFS_FSEL), 8'h0f);
      periph_drv[3] <= '{out: 8'ha5, oe: 8'hff};
      wt();
      chk("alt oe_n", pad_ctl[3].oe_n, 8'hf0);
      chk("alt out", pad_ctl[3].out[3:0], 4'h5);
      chk("alt pull", pad_ctl[3].pull, 8'hf0);
      chk("alt schm", pad_ctl[3].schm, 8'h0f);
      chk("alt ibuf", pad_ctl[3].ibuf, 8'h0f);
      chk("alt in", periph_in[3], 8'h05);
      wr(ad(3, GPB_OFS_HYST), 8'hff); wt();
      chk("hyst ibuf", pad_ctl[3].ibuf, 8'hff);
      chk("hyst schm", pad_ctl[3].schm, 8'hff);
      chk("hyst in", periph_in[3], 8'hf5);
      $display("test alt done");
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(ad(2, GPB_OFS_DOUT)); chk("dout kept", rv, 32'h58);
      wr(ad(2, GPB_OFS_DOUT), 8'h00, 4'he); rd(ad(2, GPB_OFS_DOUT));
      chk("strobe off", rv, 32'h58);
      rd(ad(3, GPB_OFS_FSEL)); chk("fsel re-rst", rv, 32'h0);
      chk("pull re-rst", pad_ctl[3].pull, 8'h00);
      $display("test reset again done");
      wrap_up();
   end
endmodule
